// [verilog/stsel_pkg.sv]
package stsel_pkg;
   // apb register byte offsets
   localparam logic [7:0] adr_ctrl     = 8'h00; // advance and jump selection codes
   localparam logic [7:0] adr_thr1     = 8'h04; // first pair of thresholds
   localparam logic [7:0] adr_thr2     = 8'h08; // second pair of thresholds
   localparam logic [7:0] adr_dwell    = 8'h0c; // dwell delay in milliseconds
   localparam logic [7:0] adr_climit   = 8'h10; // pulse counter limit
   localparam logic [7:0] adr_refmax   = 8'h14; // maximum reference
   localparam logic [7:0] adr_status   = 8'h18; // read-only live state
   localparam logic [7:0] adr_restart  = 8'h1c; // write 1 in bit 0 restarts program

   // field positions
   localparam int adv_lsb   = 0;  // advance selection code, 7 bits
   localparam int jump_lsb  = 8;  // jump selection code, 7 bits
   localparam int lo_lsb    = 0;  // lower threshold field, 16 bits
   localparam int hi_lsb    = 16; // upper threshold field, 16 bits
   localparam int code_w    = 7;
   localparam int val_w     = 16;

   // status bits
   localparam int st_adv    = 0;
   localparam int st_jump   = 1;
   localparam int st_elap   = 2;
   localparam int st_frozen = 3;
   localparam int st_entry  = 4;

   // timing: dwell counted in milliseconds of a 250 mhz clock
   localparam int clk_mhz         = 250;
   localparam int ms_ns           = 1000000;
   localparam int cycles_per_ms   = ms_ns / 4; // ns per ms over 4 ns period

   // band widths in per cent of maximum reference
   localparam int enter_pct = 4;
   localparam int at_pct    = 1;
   localparam int pct_full  = 100;

   // selection codes of interest
   localparam logic [6:0] sel_none    = 7'h00;
   localparam logic [6:0] sel_a1h2dly = 7'h22; // 34
   localparam logic [6:0] sel_a2l2dly = 7'h23;
   localparam logic [6:0] sel_sv1o    = 7'h24; // 36
   localparam logic [6:0] sel_sv1u    = 7'h27; // 39
   localparam logic [6:0] sel_sv1od   = 7'h2a; // 42
   localparam logic [6:0] sel_sv1ud   = 7'h2d; // 45
   localparam logic [6:0] sel_cnt_hi  = 7'h30; // 48
   localparam logic [6:0] sel_cnt_lo  = 7'h31;
   localparam logic [6:0] sel_logic   = 7'h32;
   localparam logic [6:0] sel_enter   = 7'h33;
   localparam logic [6:0] sel_atref   = 7'h34;
   localparam logic [6:0] sel_di5_cmp = 7'h35; // 53
   localparam logic [6:0] sel_di4_cmp = 7'h39; // 57
   localparam logic [6:0] sel_dly_di  = 7'h3d; // 61
   localparam logic [6:0] sel_dly_a2h = 7'h42; // 66
   localparam logic [6:0] sel_dly_a2l = 7'h43;
   localparam logic [6:0] sel_dly_a1h = 7'h44; // 68

   // trigger decision enum
   typedef enum logic [1:0] {
      stsel_hold = 2'b00,
      stsel_next = 2'b01,
      stsel_jump = 2'b10
   } stsel_act_t;
endpackage

// [verilog/stsel_dwell.sv]
`timescale 1ns/1ps
// dwell timer: restarts on state entry, flags when delay has elapsed
module stsel_dwell #(
   parameter int   CYC_PER_MS = stsel_pkg::cycles_per_ms,
   parameter int   MS_W       = 16
) (
   // clock and reset
   input  wire logic            pclk,
   input  wire logic            presetn,
   // control
   input  wire logic            entry,     // one-cycle pulse on state entry
   input  wire logic [MS_W-1:0] delay_ms,  // programmed delay
   // result
   output logic                 elapsed
);
   logic [31:0]     pre;        // cycles within one millisecond
   logic [MS_W-1:0] ms;         // whole milliseconds counted
   logic [31:0]     next_pre;
   logic [MS_W-1:0] next_ms;
   logic            next_elapsed;

   // count up; the count saturates so a long stay cannot wrap back to false
   always_comb begin
      next_pre     = pre;
      next_ms      = ms;
      next_elapsed = elapsed;
      if (entry) begin // R18
         next_pre     = 32'h0;
         next_ms      = '0;
         next_elapsed = 1'b0;
      end else if (ms >= delay_ms) begin
         next_elapsed = 1'b1;
      end else if (pre == 32'(CYC_PER_MS - 1)) begin
         next_pre = 32'h0;
         next_ms  = ms + 1'b1;
      end else begin
         next_pre = pre + 32'h1;
      end
   end

   // register stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre     <= 32'h0;
         ms      <= '0;
         elapsed <= 1'b0;
      end else begin
         pre     <= next_pre;
         ms      <= next_ms;
         elapsed <= next_elapsed;
      end
   end
endmodule

// [verilog/stsel_cond.sv]
`timescale 1ns/1ps
// combinational condition mux for one selection code
module stsel_cond #(
   parameter int W = stsel_pkg::val_w
) (
   // selection
   input  wire logic [6:0]   code,
   // analog comparisons, precomputed
   input  wire logic         a1_lo1,
   input  wire logic         a1_hi1,
   input  wire logic         a2_lo2,
   input  wire logic         a2_hi2,
   input  wire logic         a1_hi2,
   // other sources
   input  wire logic [4:0]   din,
   input  wire logic [2:0]   sup,
   input  wire logic         cnt_hi,
   input  wire logic         cnt_lo,
   input  wire logic         logic_res,
   input  wire logic         enter_band,
   input  wire logic         on_ref,
   input  wire logic         dly,
   // result
   output logic              hit
);
   logic [6:0] ofs; // offset within a group of codes

   // codes outside 34..68 give no trigger
   always_comb begin
      hit = 1'b0;
      ofs = 7'h0;
      if (code == stsel_pkg::sel_a1h2dly) begin
         hit = a1_hi2 | dly; // R1
      end else if (code == stsel_pkg::sel_a2l2dly) begin
         hit = a2_lo2 | dly; // R2
      end else if (code >= stsel_pkg::sel_sv1o && code < stsel_pkg::sel_sv1u) begin
         ofs = code - stsel_pkg::sel_sv1o;
         hit = sup[ofs[1:0]]; // R3
      end else if (code >= stsel_pkg::sel_sv1u && code < stsel_pkg::sel_sv1od) begin
         ofs = code - stsel_pkg::sel_sv1u;
         hit = sup[ofs[1:0]]; // R4
      end else if (code >= stsel_pkg::sel_sv1od && code < stsel_pkg::sel_sv1ud) begin
         ofs = code - stsel_pkg::sel_sv1od;
         hit = sup[ofs[1:0]] | dly; // R5
      end else if (code >= stsel_pkg::sel_sv1ud && code < stsel_pkg::sel_cnt_hi) begin
         ofs = code - stsel_pkg::sel_sv1ud;
         hit = sup[ofs[1:0]] | dly; // R6
      end else if (code == stsel_pkg::sel_cnt_hi) begin
         hit = cnt_hi; // R7
      end else if (code == stsel_pkg::sel_cnt_lo) begin
         hit = cnt_lo; // R8
      end else if (code == stsel_pkg::sel_logic) begin
         hit = logic_res; // R9
      end else if (code == stsel_pkg::sel_enter) begin
         hit = enter_band; // R10
      end else if (code == stsel_pkg::sel_atref) begin
         hit = on_ref; // R11
      end else if (code >= stsel_pkg::sel_di5_cmp && code < stsel_pkg::sel_di4_cmp) begin
         ofs = code - stsel_pkg::sel_di5_cmp;
         case (ofs[1:0]) // R12
            2'h0:    hit = din[4] & a1_lo1;
            2'h1:    hit = din[4] & a2_lo2;
            2'h2:    hit = din[4] & a1_hi1;
            default: hit = din[4] & a2_hi2;
         endcase
      end else if (code >= stsel_pkg::sel_di4_cmp && code < stsel_pkg::sel_dly_di) begin
         ofs = code - stsel_pkg::sel_di4_cmp;
         case (ofs[1:0]) // R13
            2'h0:    hit = din[3] & a1_lo1;
            2'h1:    hit = din[3] & a2_lo2;
            2'h2:    hit = din[3] & a1_hi1;
            default: hit = din[3] & a2_hi2;
         endcase
      end else if (code >= stsel_pkg::sel_dly_di && code < stsel_pkg::sel_dly_a2h) begin
         ofs = code - stsel_pkg::sel_dly_di;
         hit = dly & din[ofs[2:0]]; // R14
      end else if (code == stsel_pkg::sel_dly_a2h) begin
         hit = dly & a2_hi2; // R15
      end else if (code == stsel_pkg::sel_dly_a2l) begin
         hit = dly & a2_lo2; // R15
      end else if (code == stsel_pkg::sel_dly_a1h) begin
         hit = dly & a1_hi1; // R15
      end else begin
         hit = 1'b0; // R16
      end
   end
endmodule

// [verilog/stsel_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// R1: code 34: input one over upper two, or delay
// R2: code 35: input two under lower two, or delay
// R3: codes 36-38 pass supervision channel result
// R4: codes 39-41 same supervision results again
// R5: codes 42-44 supervision or delay
// R6: codes 45-47 same as supervision or delay
// R7: code 48: counter above limit
// R8: code 49: counter below limit
// R9: code 50: combined logic result
// R10: code 51: within four percent of reference
// R11: code 52: within one percent of reference
// R12: codes 53-56 comparisons gated by input five
// R13: codes 57-60 comparisons gated by input four
// R14: codes 61-65 delay and digital input
// R15: codes 66-68 delay and analog comparison
// R16: code 0 no trigger; both codes 0 freeze until restart
// R17: jump trigger beats advance trigger
// R18: evaluate each cycle, strict compares, restart dwell
module stsel_top #(
   parameter int W          = stsel_pkg::val_w,
   parameter int CYC_PER_MS = stsel_pkg::cycles_per_ms
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // apb slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // condition sources
   input  wire logic [W-1:0] analog_input_one,
   input  wire logic [W-1:0] analog_input_two,
   input  wire logic [4:0]   digital_in,          // inputs one to five, bit 0 first
   input  wire logic [2:0]   supervision_result,  // channels one to three
   input  wire logic [W-1:0] pulse_count,
   input  wire logic         combined_logic_result,
   input  wire logic [W-1:0] output_speed,
   input  wire logic [W-1:0] speed_reference,
   // state machine side
   input  wire logic         state_entry,         // pulse when a new state is entered
   output logic [1:0]        action,              // stsel_act_t code
   output logic              advance_trigger,
   output logic              jump_trigger,
   output logic              state_frozen,
   output logic              program_restart
);
   // configuration registers
   logic [6:0]   adv_code;
   logic [6:0]   jump_code;
   logic [W-1:0] first_upper_threshold;
   logic [W-1:0] first_lower_threshold;
   logic [W-1:0] second_upper_threshold;
   logic [W-1:0] second_lower_threshold;
   logic [W-1:0] state_dwell_delay;
   logic [W-1:0] counter_limit;
   logic [W-1:0] max_reference;
   logic [6:0]   next_adv_code;
   logic [6:0]   next_jump_code;
   logic [W-1:0] next_fut, next_flt, next_sut, next_slt;
   logic [W-1:0] next_dwell, next_climit, next_refmax;
   logic [31:0]  next_prdata;
   logic         next_restart;
   logic         next_frozen;

   // decoded conditions
   logic         wr_acc;    // write access phase
   logic         rd_acc;    // read setup phase, loads prdata
   logic         known;     // address hits a register
   logic         dly;       // dwell elapsed
   logic         adv_hit;
   logic         jump_hit;
   logic [W:0]   err;       // speed error magnitude
   logic         entering_reference_band;
   logic         on_reference;
   logic         count_above_limit;
   logic         count_below_limit;

   // strict compare: greater than
   function automatic logic gt(input logic [W-1:0] a, input logic [W-1:0] b);
      return a > b; // R18
   endfunction

   // band test: error times 100 within pct times max reference
   function automatic logic in_band(input logic [W:0] e, input logic [W-1:0] m,
                                    input int pct);
      logic [W+7:0] lhs;
      logic [W+7:0] rhs;
      lhs = (W+8)'(e) * (W+8)'(stsel_pkg::pct_full);
      rhs = (W+8)'(m) * (W+8)'(pct);
      return lhs <= rhs; // boundary counts as inside
   endfunction

   // apb always answers at once; unmapped reads give zero with an error
   assign pready  = 1'b1;
   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & ~penable & ~pwrite;
   assign known   = paddr <= stsel_pkg::adr_restart && paddr[1:0] == 2'b00;
   assign pslverr = psel & penable & ~known;

   // speed error and limit comparisons, recomputed every cycle
   assign err = (output_speed >= speed_reference) ?
                {1'b0, output_speed - speed_reference} :
                {1'b0, speed_reference - output_speed};
   assign entering_reference_band = in_band(err, max_reference, stsel_pkg::enter_pct); // R10
   assign on_reference            = in_band(err, max_reference, stsel_pkg::at_pct);    // R11
   assign count_above_limit       = gt(pulse_count, counter_limit);                    // R7
   assign count_below_limit       = gt(counter_limit, pulse_count);                    // R8

   // dwell timer, restarted by state entry
   stsel_dwell #(.CYC_PER_MS(CYC_PER_MS), .MS_W(W)) u_dwell (
      .pclk     (pclk),
      .presetn  (presetn),
      .entry    (state_entry),
      .delay_ms (state_dwell_delay),
      .elapsed  (dly)
   );

   // advance trigger mux
   stsel_cond #(.W(W)) u_adv (
      .code       (adv_code),
      .a1_lo1     (gt(first_lower_threshold, analog_input_one)),
      .a1_hi1     (gt(analog_input_one, first_upper_threshold)),
      .a2_lo2     (gt(second_lower_threshold, analog_input_two)),
      .a2_hi2     (gt(analog_input_two, second_upper_threshold)),
      .a1_hi2     (gt(analog_input_one, second_upper_threshold)),
      .din        (digital_in),
      .sup        (supervision_result),
      .cnt_hi     (count_above_limit),
      .cnt_lo     (count_below_limit),
      .logic_res  (combined_logic_result),
      .enter_band (entering_reference_band),
      .on_ref     (on_reference),
      .dly        (dly),
      .hit        (adv_hit)
   );

   // jump trigger mux uses the same decoding
   stsel_cond #(.W(W)) u_jump (
      .code       (jump_code),
      .a1_lo1     (gt(first_lower_threshold, analog_input_one)),
      .a1_hi1     (gt(analog_input_one, first_upper_threshold)),
      .a2_lo2     (gt(second_lower_threshold, analog_input_two)),
      .a2_hi2     (gt(analog_input_two, second_upper_threshold)),
      .a1_hi2     (gt(analog_input_one, second_upper_threshold)),
      .din        (digital_in),
      .sup        (supervision_result),
      .cnt_hi     (count_above_limit),
      .cnt_lo     (count_below_limit),
      .logic_res  (combined_logic_result),
      .enter_band (entering_reference_band),
      .on_ref     (on_reference),
      .dly        (dly),
      .hit        (jump_hit)
   );

   // triggers are combinational so the state machine sees them this cycle
   always_comb begin
      advance_trigger = adv_hit;
      jump_trigger    = jump_hit;
      if (jump_hit) begin
         action = stsel_pkg::stsel_jump; // R17
      end else if (adv_hit) begin
         action = stsel_pkg::stsel_next;
      end else begin
         action = stsel_pkg::stsel_hold;
      end
   end

   // register writes, read mux, freeze flag
   always_comb begin
      next_adv_code  = adv_code;
      next_jump_code = jump_code;
      next_fut       = first_upper_threshold;
      next_flt       = first_lower_threshold;
      next_sut       = second_upper_threshold;
      next_slt       = second_lower_threshold;
      next_dwell     = state_dwell_delay;
      next_climit    = counter_limit;
      next_refmax    = max_reference;
      next_restart   = 1'b0;
      next_prdata    = 32'h0;
      if (wr_acc) begin
         if (paddr == stsel_pkg::adr_ctrl) begin
            next_adv_code  = pwdata[stsel_pkg::adv_lsb +: stsel_pkg::code_w];
            next_jump_code = pwdata[stsel_pkg::jump_lsb +: stsel_pkg::code_w];
         end else if (paddr == stsel_pkg::adr_thr1) begin
            next_flt = pwdata[stsel_pkg::lo_lsb +: W];
            next_fut = pwdata[stsel_pkg::hi_lsb +: W];
         end else if (paddr == stsel_pkg::adr_thr2) begin
            next_slt = pwdata[stsel_pkg::lo_lsb +: W];
            next_sut = pwdata[stsel_pkg::hi_lsb +: W];
         end else if (paddr == stsel_pkg::adr_dwell) begin
            next_dwell = pwdata[W-1:0];
         end else if (paddr == stsel_pkg::adr_climit) begin
            next_climit = pwdata[W-1:0];
         end else if (paddr == stsel_pkg::adr_refmax) begin
            next_refmax = pwdata[W-1:0];
         end else if (paddr == stsel_pkg::adr_restart) begin
            next_restart = pwdata[0]; // R16
         end
      end
      if (rd_acc) begin
         if (paddr == stsel_pkg::adr_ctrl) begin
            next_prdata[stsel_pkg::adv_lsb +: stsel_pkg::code_w]  = adv_code;
            next_prdata[stsel_pkg::jump_lsb +: stsel_pkg::code_w] = jump_code;
         end else if (paddr == stsel_pkg::adr_thr1) begin
            next_prdata = {first_upper_threshold, first_lower_threshold};
         end else if (paddr == stsel_pkg::adr_thr2) begin
            next_prdata = {second_upper_threshold, second_lower_threshold};
         end else if (paddr == stsel_pkg::adr_dwell) begin
            next_prdata[W-1:0] = state_dwell_delay;
         end else if (paddr == stsel_pkg::adr_climit) begin
            next_prdata[W-1:0] = counter_limit;
         end else if (paddr == stsel_pkg::adr_refmax) begin
            next_prdata[W-1:0] = max_reference;
         end else if (paddr == stsel_pkg::adr_status) begin
            next_prdata[stsel_pkg::st_adv]    = adv_hit;
            next_prdata[stsel_pkg::st_jump]   = jump_hit;
            next_prdata[stsel_pkg::st_elap]   = dly;
            next_prdata[stsel_pkg::st_frozen] = state_frozen;
         end
      end
      // frozen while both selections are off; cleared only by restart
      if (next_restart) begin
         next_frozen = 1'b0; // R16
      end else if (adv_code == stsel_pkg::sel_none && jump_code == stsel_pkg::sel_none) begin
         next_frozen = 1'b1; // R16
      end else begin
         next_frozen = state_frozen;
      end
   end

   // prdata is loaded at the setup edge, so it stands through the access
   // phase and the master takes it at the edge where pready is high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adv_code               <= stsel_pkg::sel_none;
         jump_code              <= stsel_pkg::sel_none;
         first_upper_threshold  <= '0;
         first_lower_threshold  <= '0;
         second_upper_threshold <= '0;
         second_lower_threshold <= '0;
         state_dwell_delay      <= '0;
         counter_limit          <= '0;
         max_reference          <= '0;
         program_restart        <= 1'b0;
         prdata                 <= 32'h0;
         state_frozen           <= 1'b0;
      end else begin
         adv_code               <= next_adv_code;
         jump_code              <= next_jump_code;
         first_upper_threshold  <= next_fut;
         first_lower_threshold  <= next_flt;
         second_upper_threshold <= next_sut;
         second_lower_threshold <= next_slt;
         state_dwell_delay      <= next_dwell;
         counter_limit          <= next_climit;
         max_reference          <= next_refmax;
         program_restart        <= next_restart;
         prdata                 <= next_prdata;
         state_frozen           <= next_frozen;
      end
   end
endmodule

// [bench/stsel_properties.sv]
`timescale 1ns/1ps
// port-level checker for the trigger selector
module stsel_properties (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // sources and decision
   input wire logic [2:0]  supervision_result,
   input wire logic        combined_logic_result,
   input wire logic [1:0]  action,
   input wire logic        advance_trigger,
   input wire logic        jump_trigger,
   input wire logic        state_frozen,
   input wire logic        program_restart
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       wr;    // write access edge
   logic       rs;    // restart write
   logic [6:0] adv_c; // advance code
   logic [6:0] jmp_c; // jump code
   assign wr = psel & penable & pwrite & pready;
   assign rs = wr & (paddr == stsel_pkg::adr_restart) & pwdata[0];
   // shadow of the control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adv_c <= 7'h00;
         jmp_c <= 7'h00;
      end else if (wr && paddr == stsel_pkg::adr_ctrl) begin
         adv_c <= pwdata[6:0];
         jmp_c <= pwdata[14:8];
      end
   end
   sequence s_restart_wr;
      rs;
   endsequence
   sequence s_one_pulse;
      program_restart ##1 !program_restart;
   endsequence
   AST_NONE: assert property (adv_c == 7'h00 |-> !advance_trigger)
      else $error("trigger with no code");
   AST_SUPV: assert property (adv_c >= 7'h24 && adv_c <= 7'h29 |->
      advance_trigger == supervision_result[(adv_c - 7'h24) % 3])
      else $error("supervision mismatch");
   AST_LOGIC: assert property (adv_c == 7'h32 |->
      advance_trigger == combined_logic_result)
      else $error("logic mismatch");
   AST_PRIO: assert property (jump_trigger |-> action == 2'h2)
      else $error("jump not preferred");
   AST_NEXT: assert property (advance_trigger && !jump_trigger |-> action == 2'h1)
      else $error("advance not taken");
   AST_IDLE: assert property (!advance_trigger && !jump_trigger |-> action == 2'h0)
      else $error("action without trigger");
   AST_RESTART: assert property (s_restart_wr |=> s_one_pulse)
      else $error("restart pulse wrong");
   AST_FREEZE: assert property (adv_c == 7'h00 && jmp_c == 7'h00 && !rs
      |=> state_frozen)
      else $error("state not frozen");
   AST_STAYS: assert property (state_frozen && !rs |=> $stable(state_frozen))
      else $error("freeze left");
   AST_READY: assert property (psel && penable |-> pready)
      else $error("no answer");
endmodule
bind stsel_top stsel_properties u_props (.*);

// [bench/stsel_seq_model.sv]
`timescale 1ns/1ps
// far-side sequence engine; entries only on request
module stsel_seq_model (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // selector side
   input  wire logic [1:0] action,
   input  wire logic       kick,        // entry request
   output logic            state_entry,
   output logic [2:0]      state        // current state number
);
   // selector already resolved jump over next
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_entry <= 1'b0;
         state       <= 3'h0;
      end else begin
         state_entry <= kick;
         if (action == stsel_pkg::stsel_jump) begin
            state <= 3'h0;
         end else if (action == stsel_pkg::stsel_next) begin
            state <= state + 3'h1;
         end
      end
   end
endmodule

// [bench/tb_stsel_top.sv]
`timescale 1ns/1ps
// bench for the trigger selector
module tb_stsel_top;
   localparam logic [15:0] P = 16'h96;  // idle input one
   localparam logic [15:0] Q = 16'h15e; // idle input two
   logic        pclk = 1'b0, presetn = 1'b0, kick = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] a1 = 16'h0, a2 = 16'h0, v = 16'h0; // levels; v feeds counter and speed
   logic [4:0]  di = 5'h0;
   logic [2:0]  sv = 3'h0; // bit 2 also drives the logic result
   logic [1:0]  action;
   logic        adv_t, jmp_t, frozen, restart, entry;
   logic [2:0]  st;
   int          bad_count = 0, cmp_count = 0, cyc = 0;
   always #2 pclk = ~pclk;
   stsel_top #(.CYC_PER_MS(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .analog_input_one(a1), .analog_input_two(a2),
      .digital_in(di), .supervision_result(sv), .pulse_count(v),
      .combined_logic_result(sv[2]), .output_speed(v), .speed_reference(16'h1f4),
      .state_entry(entry), .action(action), .advance_trigger(adv_t), .jump_trigger(jmp_t),
      .state_frozen(frozen), .program_restart(restart));
   stsel_seq_model PM (.pclk(pclk), .presetn(presetn), .action(action), .kick(kick),
      .state_entry(entry), .state(st));
   task test_done;
      $display("counts: compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // hang guard, run needs ~230 cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         test_done;
      end
   end
   task chk(input logic [31:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer, entered and left after a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      err = pslverr;
      rd = prdata;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task kk;
      kick <= 1'b1;
      @(posedge pclk);
      kick <= 1'b0;
      @(posedge pclk);
   endtask
   // set codes and levels, check decision
   task tv(input logic [15:0] c, x1, x2,
           input logic [4:0] d, input logic [2:0] s, input logic [15:0] n,
           input logic [1:0] e);
      apb(1'b1, stsel_pkg::adr_ctrl, {16'h0, c});
      a1 <= x1; a2 <= x2; di <= d; sv <= s; v <= n;
      @(posedge pclk);
      #1 chk(action, e);
      @(posedge pclk);
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, stsel_pkg::adr_status, 32'h0);
      chk(rd[stsel_pkg::st_frozen], 1'b1);
      apb(1'b0, 8'h20, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, stsel_pkg::adr_thr1, 32'h00c8_0064);
      apb(1'b1, stsel_pkg::adr_thr2, 32'h0190_012c);
      apb(1'b1, stsel_pkg::adr_climit, 32'h1f4);
      apb(1'b1, stsel_pkg::adr_refmax, 32'h3e8);
      apb(1'b1, stsel_pkg::adr_dwell, 32'hc8);
      kk;
      tv(16'h22, 16'h191, Q, 5'h0, 3'h0, 16'h0, 2'h1);
      tv(16'h22, 16'h190, Q, 5'h0, 3'h0, 16'h0, 2'h0);
      tv(16'h23, P, 16'h12b, 5'h0, 3'h0, 16'h0, 2'h1);
      tv(16'h23, P, 16'h12c, 5'h0, 3'h0, 16'h0, 2'h0);
      tv(16'h25, P, Q, 5'h0, 3'h1, 16'h0, 2'h0);
      tv(16'h26, P, Q, 5'h0, 3'h4, 16'h0, 2'h1);
      tv(16'h28, P, Q, 5'h0, 3'h2, 16'h0, 2'h1);
      tv(16'h2a, P, Q, 5'h0, 3'h0, 16'h0, 2'h0);
      tv(16'h2b, P, Q, 5'h0, 3'h2, 16'h0, 2'h1);
      tv(16'h2f, P, Q, 5'h0, 3'h4, 16'h0, 2'h1);
      tv(16'h30, P, Q, 5'h0, 3'h0, 16'h1f5, 2'h1);
      tv(16'h30, P, Q, 5'h0, 3'h0, 16'h1f4, 2'h0);
      tv(16'h31, P, Q, 5'h0, 3'h0, 16'h1f3, 2'h1);
      tv(16'h31, P, Q, 5'h0, 3'h0, 16'h1f4, 2'h0);
      tv(16'h32, P, Q, 5'h0, 3'h4, 16'h0, 2'h1);
      tv(16'h33, P, Q, 5'h0, 3'h0, 16'h21c, 2'h1);
      tv(16'h33, P, Q, 5'h0, 3'h0, 16'h21d, 2'h0);
      tv(16'h34, P, Q, 5'h0, 3'h0, 16'h1fe, 2'h1);
      tv(16'h34, P, Q, 5'h0, 3'h0, 16'h1e9, 2'h0);
      tv(16'h35, 16'h63, Q, 5'h10, 3'h0, 16'h0, 2'h1);
      tv(16'h35, 16'h63, Q, 5'h08, 3'h0, 16'h0, 2'h0);
      tv(16'h37, 16'hc9, Q, 5'h10, 3'h0, 16'h0, 2'h1);
      tv(16'h3a, P, 16'h12b, 5'h08, 3'h0, 16'h0, 2'h1);
      tv(16'h3c, P, 16'h191, 5'h10, 3'h0, 16'h0, 2'h0);
      tv(16'h3d, P, Q, 5'h01, 3'h0, 16'h0, 2'h0);
      tv(16'h42, P, 16'h191, 5'h0, 3'h0, 16'h0, 2'h0);
      tv(16'h00, 16'h191, 16'h12b, 5'h1f, 3'h7, 16'h1f5, 2'h0);
      $display("test without delay done");
      apb(1'b1, stsel_pkg::adr_dwell, 32'h0);
      kk;
      repeat (3) @(posedge pclk);
      tv(16'h22, P, Q, 5'h0, 3'h0, 16'h0, 2'h1);
      tv(16'h2e, P, Q, 5'h0, 3'h0, 16'h0, 2'h1);
      tv(16'h3d, P, Q, 5'h02, 3'h0, 16'h0, 2'h0);
      tv(16'h41, P, Q, 5'h10, 3'h0, 16'h0, 2'h1);
      tv(16'h43, P, 16'h12b, 5'h0, 3'h0, 16'h0, 2'h1);
      tv(16'h44, 16'hc8, Q, 5'h0, 3'h0, 16'h0, 2'h0);
      $display("test with delay done");
      tv(16'h2430, P, Q, 5'h0, 3'h1, 16'h1f5, 2'h2);
      tv(16'h2430, P, Q, 5'h0, 3'h0, 16'h1f5, 2'h1);
      apb(1'b1, stsel_pkg::adr_restart, 32'h1);
      chk(frozen, 1'b0);
      tv(16'h0, P, Q, 5'h0, 3'h1, 16'h1f5, 2'h0);
      chk(frozen, 1'b1);
      $display("test priority and freeze done");
      test_done;
   end
endmodule
